// ---- design/shadow_nvm_save_restore.sv ----
// Functional notes
// - Save or restore only with matching key.
// - Per-word code corrects one, detects two.
// - Image checksum verified on restore, flagged.
// - Start bit plus code selects command.
// - Save copies RAM 0x200-0x3CF to shadow.
// - Restore copies shadow back into RAM.
// - At end: interrupt, start clear, done set.
// - Result code: 0x00 pass, 0xFF fail.
// - Status bits: used, uncorrectable, program, checksum.
// - Corrected word sets correction flag.
// - Uncorrectable word sets uncorrectable flag.
// - Save verify mismatch sets program failure.
// - Writing 0x00 to status clears flags.
// - Reset and sleep exit clear flags.
// - Shadow holds 464 bytes of image plus checksum word.
`include "shadow_nvm_consts.svh"

module shadow_nvm_save_restore import shadow_nvm_pkg::*; #(
	parameter int RAM_BYTES = 464
) (
	// Clock and reset.
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	// Register port.
	input wire logic [9:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [7:0] RDATA_O,
	// Sleep pin and interrupt.
	input wire logic SLEEP_I,
	output logic IRQ_O
);

	// ----------------------------------------
	// Declarations.
	// ----------------------------------------
	logic [7:0] cfg_ram [RAM_BYTES];
	logic [7:0] key_q [4];
	logic [7:0] cmd_q, result_q, event_q, mask_q, rdata_q;
	logic [3:0] status_q, status_set;
	logic status_clr, irq_q, restore_fail_q, cmd_wr, busy, finish;
	logic sleep_s1_q, sleep_s2_q, sleep_s3_q, sleep_q, sleep_exit;
	seq_state_type state_q, state_d;
	word_index_type idx_q;
	logic [31:0] sum_q, ram_word, save_word, dec_data;
	code_word_type expect_q, enc_code;
	logic dec_single, dec_double;
	logic [8:0] host_idx, word_base;

	shadow_word_if nvm ();

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	function automatic logic in_ram(input logic [9:0] a);
		in_ram = (a >= `OFS_RAM_FIRST) && (a <= `OFS_RAM_LAST);
	endfunction

	function automatic logic [8:0] ram_index(input logic [9:0] a);
		logic [9:0] diff;
		diff = a - `OFS_RAM_FIRST;
		ram_index = diff[8:0];
	endfunction

	assign host_idx = ram_index(ADDR_I);
	assign word_base = {idx_q, 2'b00};
	assign busy = (state_q != ST_IDLE);
	assign cmd_wr = WR_I && (ADDR_I == `OFS_COMMAND) && !busy;
	assign finish = (state_q == ST_FINISH);

	// ----------------------------------------
	// Word codec and shadow array.
	// ----------------------------------------
	secded_codec u_codec (
		.enc_data_i(save_word),
		.enc_code_o(enc_code),
		.dec_code_i(nvm.rdata),
		.dec_data_o(dec_data),
		.dec_single_o(dec_single),
		.dec_double_o(dec_double)
	);

	shadow_store #(
		.DEPTH(`SHADOW_WORDS)
	) u_store (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RESETN_I),
		.port(nvm.mem)
	);

	// ----------------------------------------
	// Sleep pin synchroniser.
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sleep_s1_q <= 1'b0;
			sleep_s2_q <= 1'b0;
			sleep_s3_q <= 1'b0;
		end else begin
			sleep_s1_q <= SLEEP_I;
			sleep_s2_q <= sleep_s1_q;
			sleep_s3_q <= sleep_s2_q;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sleep_q <= 1'b0;
		end else if (sleep_s2_q == sleep_s3_q) begin
			sleep_q <= sleep_s3_q;
		end
	end

	assign sleep_exit = sleep_q && !sleep_s3_q && !sleep_s2_q;

	// ----------------------------------------
	// Key registers.
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			for (int i = 0; i < 4; i++) begin
				key_q[i] <= 8'h00;
			end
		end else if (WR_I) begin
			case (ADDR_I)
				`OFS_KEY3: key_q[3] <= WDATA_I;
				`OFS_KEY2: key_q[2] <= WDATA_I;
				`OFS_KEY1: key_q[1] <= WDATA_I;
				`OFS_KEY0: key_q[0] <= WDATA_I;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Command register and sequencer.
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			cmd_q <= 8'h00;
		end else if (cmd_wr) begin
			cmd_q <= WDATA_I;
			cmd_q[`CMD_DONE_BIT] <= 1'b0;
		end else if (finish) begin
			cmd_q[`CMD_START_BIT] <= 1'b0;
			cmd_q[`CMD_DONE_BIT] <= 1'b1;
		end
	end

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cmd_wr && WDATA_I[`CMD_START_BIT]) begin
					state_d = ST_FINISH;
					if ({key_q[3], key_q[2], key_q[1], key_q[0]} == `UNLOCK_KEY) begin
						if (WDATA_I[`CMD_CODE_MSB:0] == `CMD_CODE_SAVE) begin
							state_d = ST_SAVE_WR;
						end
						if (WDATA_I[`CMD_CODE_MSB:0] == `CMD_CODE_RESTORE) begin
							state_d = ST_RST_RD;
						end
					end
				end
			end
			ST_SAVE_WR: state_d = ST_SAVE_RB;
			ST_SAVE_RB: state_d = ST_SAVE_CMP;
			ST_SAVE_CMP: state_d = (idx_q == `CSUM_WORD) ? ST_FINISH : ST_SAVE_WR;
			ST_RST_RD: state_d = ST_RST_USE;
			ST_RST_USE: state_d = (idx_q == `CSUM_WORD) ? ST_FINISH : ST_RST_RD;
			ST_FINISH: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			idx_q <= '0;
		end else if (state_q == ST_IDLE) begin
			idx_q <= '0;
		end else if (state_q == ST_SAVE_CMP || state_q == ST_RST_USE) begin
			idx_q <= idx_q + 7'd1;
		end
	end

	// ----------------------------------------
	// Image words and checksum.
	// ----------------------------------------
	always_comb begin
		ram_word = '0;
		if (idx_q < `IMAGE_WORDS) begin
			ram_word = {cfg_ram[word_base], cfg_ram[word_base + 9'd1],
				cfg_ram[word_base + 9'd2], cfg_ram[word_base + 9'd3]};
		end
	end

	assign save_word = (idx_q == `CSUM_WORD) ? sum_q : ram_word;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			sum_q <= '0;
		end else if (state_q == ST_IDLE) begin
			sum_q <= '0;
		end else if (state_q == ST_SAVE_CMP && idx_q != `CSUM_WORD) begin
			sum_q <= sum_q + ram_word;
		end else if (state_q == ST_RST_USE && idx_q != `CSUM_WORD) begin
			sum_q <= sum_q + dec_data;
		end
	end

	// ----------------------------------------
	// Shadow port drive.
	// ----------------------------------------
	assign nvm.addr = idx_q;
	assign nvm.wdata = enc_code;
	assign nvm.we = (state_q == ST_SAVE_WR);
	assign nvm.re = (state_q == ST_SAVE_RB) || (state_q == ST_RST_RD);

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			expect_q <= '0;
		end else if (state_q == ST_SAVE_WR) begin
			expect_q <= enc_code;
		end
	end

	// ----------------------------------------
	// Configuration RAM.
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I) begin
		if (state_q == ST_RST_USE && idx_q != `CSUM_WORD) begin
			cfg_ram[word_base] <= dec_data[31:24];
			cfg_ram[word_base + 9'd1] <= dec_data[23:16];
			cfg_ram[word_base + 9'd2] <= dec_data[15:8];
			cfg_ram[word_base + 9'd3] <= dec_data[7:0];
		end else if (WR_I && in_ram(ADDR_I) && !busy) begin
			cfg_ram[host_idx] <= WDATA_I;
		end
	end

	// ----------------------------------------
	// Status flags and result code.
	// ----------------------------------------
	always_comb begin
		status_set = 4'h0;
		if (state_q == ST_RST_USE) begin
			status_set[`ST_ECC_USED] = dec_single;
			status_set[`ST_ECC_FAIL] = dec_double;
			status_set[`ST_CSUM_FAIL] = idx_q == `CSUM_WORD && dec_data != sum_q;
		end
		status_set[`ST_PROG_FAIL] = state_q == ST_SAVE_CMP && nvm.rdata != expect_q;
	end

	assign status_clr = (WR_I && ADDR_I == `OFS_STATUS && WDATA_I == `STATUS_CLEAR_VALUE)
		|| sleep_exit;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			status_q <= 4'h0;
		end else begin
			status_q <= (status_clr ? 4'h0 : status_q) | status_set;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			restore_fail_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			restore_fail_q <= 1'b0;
		end else if (state_q == ST_RST_USE) begin
			restore_fail_q <= restore_fail_q || status_set[`ST_ECC_FAIL]
				|| status_set[`ST_CSUM_FAIL];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			result_q <= `RESULT_PASS;
		end else if (state_q == ST_RST_USE && idx_q == `CSUM_WORD) begin
			result_q <= (restore_fail_q || status_set[`ST_ECC_FAIL] || status_set[`ST_CSUM_FAIL])
				? `RESULT_FAIL : `RESULT_PASS;
		end
	end

	// ----------------------------------------
	// Completion event, mask and interrupt.
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			event_q <= 8'h00;
		end else begin
			if (WR_I && ADDR_I == `OFS_EVENT) begin
				event_q <= event_q & ~WDATA_I;
			end
			if (finish) begin
				event_q[`EVT_DONE] <= 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mask_q <= `MASK_RESET;
		end else if (WR_I && ADDR_I == `OFS_MASK) begin
			mask_q <= WDATA_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(event_q & mask_q);
		end
	end

	assign IRQ_O = irq_q;

	// ----------------------------------------
	// Read data.
	// ----------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			rdata_q <= 8'h00;
		end else if (RD_I) begin
			rdata_q <= 8'h00;
			if (in_ram(ADDR_I)) begin
				rdata_q <= cfg_ram[host_idx];
			end
			case (ADDR_I)
				`OFS_COMMAND: rdata_q <= cmd_q;
				`OFS_KEY3: rdata_q <= key_q[3];
				`OFS_KEY2: rdata_q <= key_q[2];
				`OFS_KEY1: rdata_q <= key_q[1];
				`OFS_KEY0: rdata_q <= key_q[0];
				`OFS_RESULT: rdata_q <= result_q;
				`OFS_STATUS: rdata_q <= {4'h0, status_q};
				`OFS_EVENT: rdata_q <= event_q;
				`OFS_MASK: rdata_q <= mask_q;
				default: begin
				end
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign RDATA_O = rdata_q;

endmodule // shadow_nvm_save_restore

// ---- pkg/shadow_nvm_consts.svh ----
`ifndef SHADOW_NVM_CONSTS_SVH
`define SHADOW_NVM_CONSTS_SVH

// ----------------------------------------
// Register offsets.
// ----------------------------------------
`define OFS_COMMAND 10'h000
`define OFS_KEY3 10'h0B0
`define OFS_KEY2 10'h0B1
`define OFS_KEY1 10'h0B2
`define OFS_KEY0 10'h0B3
`define OFS_RESULT 10'h0D0
`define OFS_STATUS 10'h0F9
`define OFS_EVENT 10'h0FA
`define OFS_MASK 10'h0FB
`define OFS_RAM_FIRST 10'h200
`define OFS_RAM_LAST 10'h3CF

// ----------------------------------------
// Command and key values.
// ----------------------------------------
`define UNLOCK_KEY 32'hA53C0F5A
`define CMD_START_BIT 7
`define CMD_DONE_BIT 6
`define CMD_CODE_MSB 5
`define CMD_CODE_SAVE 6'h15
`define CMD_CODE_RESTORE 6'h16

// ----------------------------------------
// Status fields and reset values.
// ----------------------------------------
`define ST_ECC_USED 0
`define ST_ECC_FAIL 1
`define ST_PROG_FAIL 2
`define ST_CSUM_FAIL 3
`define STATUS_CLEAR_VALUE 8'h00
`define RESULT_PASS 8'h00
`define RESULT_FAIL 8'hFF
`define EVT_DONE 0
`define MASK_RESET 8'h01

// ----------------------------------------
// Image layout.
// ----------------------------------------
`define IMAGE_WORDS 7'd116
`define CSUM_WORD 7'd116
`define SHADOW_WORDS 128
`define DATA_BITS 32
`define CODE_BITS 39

`endif

// ---- pkg/shadow_nvm_pkg.sv ----
package shadow_nvm_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SAVE_WR = 3'b001,
		ST_SAVE_RB = 3'b010,
		ST_SAVE_CMP = 3'b011,
		ST_RST_RD = 3'b100,
		ST_RST_USE = 3'b101,
		ST_FINISH = 3'b110
	} seq_state_type;

	typedef logic [38:0] code_word_type;
	typedef logic [6:0] word_index_type;

endpackage

// ---- pkg/shadow_word_if.sv ----
interface shadow_word_if;
	import shadow_nvm_pkg::*;
	word_index_type addr;
	code_word_type wdata;
	code_word_type rdata;
	logic we;
	logic re;

	modport ctrl (
		output addr,
		output wdata,
		output we,
		output re,
		input rdata
	);

	modport mem (
		input addr,
		input wdata,
		input we,
		input re,
		output rdata
	);
endinterface

// ---- design/shadow_store.sv ----
`include "shadow_nvm_consts.svh"

module shadow_store import shadow_nvm_pkg::*; #(
	parameter int DEPTH = `SHADOW_WORDS
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Word port.
	shadow_word_if.mem port
);

	code_word_type cells [DEPTH];

	// ----------------------------------------
	// Nonvolatile word array.
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (port.we) begin
			cells[port.addr] <= port.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port.rdata <= '0;
		end else if (port.re) begin
			port.rdata <= cells[port.addr];
		end
	end

endmodule // shadow_store

// ---- design/secded_codec.sv ----
`include "shadow_nvm_consts.svh"

module secded_codec import shadow_nvm_pkg::*; (
	// Encoder side.
	input wire logic [31:0] enc_data_i,
	output code_word_type enc_code_o,
	// Decoder side.
	input code_word_type dec_code_i,
	output logic [31:0] dec_data_o,
	output logic dec_single_o,
	output logic dec_double_o
);

	// ----------------------------------------
	// Encoder.
	// ----------------------------------------
	always_comb begin
		int j;
		j = 0;
		enc_code_o = '0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				enc_code_o[p] = enc_data_i[j];
				j++;
			end
		end
		for (int b = 0; b < 6; b++) begin
			for (int p = 1; p < 39; p++) begin
				if (((p >> b) & 1) == 1 && p != (1 << b)) begin
					enc_code_o[1 << b] = enc_code_o[1 << b] ^ enc_code_o[p];
				end
			end
		end
		enc_code_o[0] = ^enc_code_o[38:1];
	end

	// ----------------------------------------
	// Decoder.
	// ----------------------------------------
	always_comb begin
		int j;
		logic [5:0] syn;
		logic par;
		code_word_type fixed;
		j = 0;
		syn = '0;
		par = ^dec_code_i;
		fixed = dec_code_i;
		for (int p = 1; p < 39; p++) begin
			if (dec_code_i[p]) begin
				syn = syn ^ p[5:0];
			end
		end
		dec_single_o = par;
		dec_double_o = (syn != 6'h00) && !par;
		if (par && syn != 6'h00 && syn < 6'd39) begin
			fixed[syn] = !fixed[syn];
		end
		if (par && syn >= 6'd39) begin
			dec_single_o = 1'b0;
			dec_double_o = 1'b1;
		end
		dec_data_o = '0;
		for (int p = 1; p < 39; p++) begin
			if ((p & (p - 1)) != 0) begin
				dec_data_o[j] = fixed[p];
				j++;
			end
		end
	end

endmodule // secded_codec

// ---- tb/shadow_nvm_properties.sv ----
`include "shadow_nvm_consts.svh"

module shadow_nvm_checker import shadow_nvm_pkg::*; #(
	parameter int RAM_BYTES = 464
) (
	// Clock and reset.
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	// Register port.
	input wire logic [9:0] ADDR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [7:0] RDATA_O,
	// Sleep pin and interrupt.
	input wire logic SLEEP_I,
	input wire logic IRQ_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESETN_I);

	// ----------------------------------------
	// Shadow copies of the key and the mask.
	// ----------------------------------------
	logic [31:0] key_q;
	logic mask_q;
	logic cmd_wr;
	logic key_ok;

	assign cmd_wr = WR_I && ADDR_I == `OFS_COMMAND;
	assign key_ok = key_q == `UNLOCK_KEY;

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			key_q <= 32'h00000000;
		end else if (WR_I && ADDR_I[9:2] == 8'h2C) begin
			key_q[(3 - ADDR_I[1:0]) * 8 +: 8] <= WDATA_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mask_q <= 1'b1;
		end else if (WR_I && ADDR_I == `OFS_MASK) begin
			mask_q <= WDATA_I[0];
		end
	end

	// ----------------------------------------
	// Properties.
	// ----------------------------------------
	property p_status_hi;
		RD_I && ADDR_I == `OFS_STATUS |=> RDATA_O[7:4] == 4'h0;
	endproperty
	a_status_hi: assert property (p_status_hi) else $error("status upper bits set");

	property p_result_code;
		RD_I && ADDR_I == `OFS_RESULT |=> RDATA_O == `RESULT_PASS || RDATA_O == `RESULT_FAIL;
	endproperty
	a_result_code: assert property (p_result_code) else $error("bad result code");

	property p_mask_irq;
		WR_I && ADDR_I == `OFS_MASK && !WDATA_I[0] |-> ##2 !IRQ_O;
	endproperty
	a_mask_irq: assert property (p_mask_irq) else $error("masked interrupt high");

	property p_status_clear;
		(WR_I && ADDR_I == `OFS_STATUS && WDATA_I == `STATUS_CLEAR_VALUE)
			##2 (RD_I && ADDR_I == `OFS_STATUS) |=> RDATA_O == 8'h00;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not cleared");

	property p_sleep_clear;
		$fell(SLEEP_I) ##6 (RD_I && ADDR_I == `OFS_STATUS) |=> RDATA_O == 8'h00;
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("status kept after sleep");

	property p_badkey;
		cmd_wr && WDATA_I[7] && !key_ok && mask_q |-> ##[3:5] IRQ_O;
	endproperty
	a_badkey: assert property (p_badkey) else $error("refused command not finished");

	property p_save_busy;
		cmd_wr && WDATA_I == 8'h95 && key_ok ##1 !IRQ_O |-> !IRQ_O [*8];
	endproperty
	a_save_busy: assert property (p_save_busy) else $error("save ended too early");

	property p_save_done;
		cmd_wr && WDATA_I == {2'b10, `CMD_CODE_SAVE} && key_ok && mask_q |-> ##[340:360] IRQ_O;
	endproperty
	a_save_done: assert property (p_save_done) else $error("save did not finish");

	property p_restore_done;
		cmd_wr && WDATA_I == {2'b10, `CMD_CODE_RESTORE} && key_ok && mask_q |-> ##[200:260] IRQ_O;
	endproperty
	a_restore_done: assert property (p_restore_done) else $error("restore did not finish");

	c_save: cover property (cmd_wr && WDATA_I == 8'h95 && key_ok);
	c_restore: cover property (cmd_wr && WDATA_I == 8'h96 && key_ok);
	c_badkey: cover property (cmd_wr && WDATA_I[7] && !key_ok);
	c_unknown: cover property (cmd_wr && WDATA_I == 8'h97 && key_ok);
endmodule // shadow_nvm_checker

bind shadow_nvm_save_restore shadow_nvm_checker #(.RAM_BYTES(RAM_BYTES)) u_checker (
	.SYS_CLK_I(SYS_CLK_I),
	.RESETN_I(RESETN_I),
	.ADDR_I(ADDR_I),
	.WDATA_I(WDATA_I),
	.WR_I(WR_I),
	.RD_I(RD_I),
	.RDATA_O(RDATA_O),
	.SLEEP_I(SLEEP_I),
	.IRQ_O(IRQ_O)
);

// ---- tb/host_model.sv ----
`include "shadow_nvm_consts.svh"

module host_model (
	// Clock.
	input wire logic clk_i,
	// Answers from the device.
	input wire logic [7:0] rdata_i,
	input wire logic irq_i,
	// Requests toward the device.
	output logic [9:0] addr_o,
	output logic [7:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Bus cycles.
	// ----------------------------------------
	initial begin
		addr_o = 10'h000;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
		d = rdata_i;
	endtask

	task automatic key(input logic [31:0] k);
		wr(`OFS_KEY3, k[31:24]);
		wr(`OFS_KEY2, k[23:16]);
		wr(`OFS_KEY1, k[15:8]);
		wr(`OFS_KEY0, k[7:0]);
	endtask

	task automatic command(input logic [7:0] c, output logic ok);
		int n;
		wr(`OFS_EVENT, 8'h01);
		wr(`OFS_COMMAND, c);
		ok = 1'b0;
		for (n = 0; n < 600 && !ok; n++) begin
			@(posedge clk_i);
			ok = irq_i === 1'b1;
		end
	endtask
endmodule // host_model

// ---- tb/testbench.sv ----
`include "shadow_nvm_consts.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk;
	logic rst_n;
	logic sleep;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic irq;
	int failures;
	int checked;

	shadow_nvm_save_restore #(.RAM_BYTES(464)) dut (
		.SYS_CLK_I(sys_clk),
		.RESETN_I(rst_n),
		.ADDR_I(addr),
		.WDATA_I(wdata),
		.WR_I(wr),
		.RD_I(rd),
		.RDATA_O(rdata),
		.SLEEP_I(sleep),
		.IRQ_O(irq)
	);

	host_model host (
		.clk_i(sys_clk),
		.rdata_i(rdata),
		.irq_i(irq),
		.addr_o(addr),
		.wdata_o(wdata),
		.wr_o(wr),
		.rd_o(rd)
	);

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] pat(input int i);
		return 8'(i * 7 + 3);
	endfunction

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [9:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.rd(a, v);
		cmp(v, exp);
	endtask

	task automatic wrap_up;
		if (failures == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_reset_values;
		rc(`OFS_COMMAND, 8'h00);
		rc(`OFS_KEY3, 8'h00);
		rc(`OFS_RESULT, `RESULT_PASS);
		rc(`OFS_STATUS, 8'h00);
		rc(`OFS_EVENT, 8'h00);
		rc(`OFS_MASK, `MASK_RESET);
		rc(10'h100, 8'h00);
		host.wr(`OFS_RESULT, 8'hFF);
		rc(`OFS_RESULT, `RESULT_PASS);
		host.wr(`OFS_STATUS, 8'h0F);
		rc(`OFS_STATUS, 8'h00);
	endtask

	task automatic t_save_restore;
		logic ok;
		logic [7:0] v;
		for (int i = 0; i < 464; i++) begin
			host.wr(`OFS_RAM_FIRST + 10'(i), pat(i));
		end
		host.key(`UNLOCK_KEY);
		host.command(8'h95, ok);
		cmp({7'h00, ok}, 8'h01);
		rc(`OFS_COMMAND, 8'h55);
		host.rd(`OFS_STATUS, v);
		cmp(v & 8'h04, 8'h00);
		host.wr(`OFS_MASK, 8'h00);
		repeat (2) @(posedge sys_clk);
		cmp({7'h00, irq}, 8'h00);
		host.wr(`OFS_MASK, 8'h01);
		repeat (2) @(posedge sys_clk);
		cmp({7'h00, irq}, 8'h01);
		host.wr(`OFS_EVENT, 8'h01);
		repeat (2) @(posedge sys_clk);
		cmp({7'h00, irq}, 8'h00);
		for (int i = 0; i < 464; i++) begin
			host.wr(`OFS_RAM_FIRST + 10'(i), 8'h00);
		end
		host.command(8'h96, ok);
		cmp({7'h00, ok}, 8'h01);
		rc(`OFS_RESULT, `RESULT_PASS);
		rc(`OFS_STATUS, 8'h00);
		for (int i = 0; i < 464; i++) begin
			rc(`OFS_RAM_FIRST + 10'(i), pat(i));
		end
	endtask

	task automatic t_bad_key;
		logic ok;
		host.wr(`OFS_RAM_FIRST, 8'hEE);
		host.key(32'h5A0F3CA5);
		host.command(8'h96, ok);
		cmp({7'h00, ok}, 8'h01);
		rc(`OFS_COMMAND, 8'h56);
		rc(`OFS_RAM_FIRST, 8'hEE);
		host.key(32'hA53C0F5B);
		host.command(8'h95, ok);
		cmp({7'h00, ok}, 8'h01);
		host.key(`UNLOCK_KEY);
		host.command(8'h96, ok);
		cmp({7'h00, ok}, 8'h01);
		rc(`OFS_RAM_FIRST, pat(0));
		rc(`OFS_RAM_LAST, pat(463));
		host.wr(`OFS_RAM_FIRST, 8'hEE);
		host.command(8'h97, ok);
		cmp({7'h00, ok}, 8'h01);
		rc(`OFS_COMMAND, 8'h57);
		rc(`OFS_RAM_FIRST, 8'hEE);
	endtask

	task automatic t_sleep;
		host.wr(`OFS_STATUS, `STATUS_CLEAR_VALUE);
		rc(`OFS_STATUS, 8'h00);
		@(posedge sys_clk);
		sleep <= 1'b1;
		repeat (8) @(posedge sys_clk);
		sleep <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rc(`OFS_STATUS, 8'h00);
	endtask

	initial begin
		failures = 0;
		checked = 0;
		rst_n = 1'b0;
		sleep = 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_reset_values;
		t_save_restore;
		t_bad_key;
		t_sleep;
		wrap_up;
	end

	initial begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		wrap_up;
	end
endmodule // testbench
